/* File: hw/dsl_led_driver.sv */
`timescale 1ns/1ps
// What this block does
// - Red program-error lamp lights whenever the drive reports an error.
// - Green ready lamp lights after init completes, goes off on a drive error.
// - Yellow activity lamps show link presence and traffic on both ports.
// - Run lamp patterns run half a pattern period from error lamp patterns.
// - Run lamp off in the init state.
// - Run lamp blinks in the pre-operational state.
// - Run lamp single-flashes in the safe-operational state.
// - Run lamp steadily on in the operational state.
// - Error lamp steadily on after a controller failure.
// - Error lamp double-flashes after a watchdog timeout.
// - Error lamp single-flashes on a local error, error bit set outside init.
// - Error lamp flickers on a booting error, error bit set in init.
// - Error lamp blinks on configuration error, off when no error is flagged.
// - Builds with the CAN interface leave fieldbus lamps and port activity lamps unused.
module dsl_led_driver #(
	parameter int TICK_CYCLES = dsl_pkg::TICK_CYCLES,
	parameter bit CAN_BUILD = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Drive status
	input wire logic drive_init_done,
	input wire logic drive_error,
	// Port status
	input wire logic link_a,
	input wire logic activity_a,
	input wire logic link_b,
	input wire logic activity_b,
	// Fieldbus status
	input wire dsl_pkg::dsl_slave_t slave_state,
	input wire logic al_error_indicator,
	input wire logic ctrl_failure,
	input wire logic watchdog_timeout,
	input wire logic config_error,
	// Lamps
	output logic program_error_lamp,
	output logic drive_ready_lamp,
	output logic port_activity_lamp_a,
	output logic port_activity_lamp_b,
	output logic fieldbus_run_lamp,
	output logic fieldbus_error_lamp
);
	import dsl_pkg::*;

	typedef struct packed {
		logic prog_err;
		logic ready;
		logic act_a;
		logic act_b;
		logic run;
		logic err;
		logic [2:0] hold_a;
		logic [2:0] hold_b;
	} dsl_led_state_t;

	dsl_led_state_t st_ff;
	dsl_led_state_t nxt_st;

	logic tick;
	logic [PHASE_W-1:0] phase;
	dsl_pat_t run_pat;
	dsl_pat_t err_pat;
	logic local_err;
	logic boot_err;

	dsl_timebase #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timebase (
		.clk(clk),
		.reset(reset),
		.tick(tick),
		.phase(phase)
	);

	// Activity stretch: a new pulse reloads, so set wins over count-down
	function automatic logic [2:0] dsl_hold_next(logic act, logic tk, logic [2:0] h);
		logic [2:0] r;
		r = h;
		if (act)
			r = ACT_HOLD_TICKS;
		else if (tk && h != 3'h0)
			r = h - 3'h1;
		return r;
	endfunction : dsl_hold_next

	// Lit on link, blanked by flicker while traffic is stretched
	function automatic logic dsl_act_lamp(logic link, logic [2:0] h, logic [4:0] ph);
		return link && !(h != 3'h0 && !dsl_pat_level(PAT_FLICKER, ph));
	endfunction : dsl_act_lamp

	// Error bit set outside init means the application left its state
	assign local_err = al_error_indicator && slave_state != SL_INIT;
	assign boot_err = al_error_indicator && slave_state == SL_INIT;

	always_comb
	begin
		unique case (slave_state)
			SL_INIT: run_pat = PAT_OFF;
			SL_PREOP: run_pat = PAT_BLINK;
			SL_SAFEOP: run_pat = PAT_SINGLE;
			SL_OP: run_pat = PAT_ON;
		endcase
	end

	// Most severe class wins
	always_comb
	begin
		if (ctrl_failure)
			err_pat = PAT_ON;
		else if (watchdog_timeout)
			err_pat = PAT_DOUBLE;
		else if (local_err)
			err_pat = PAT_SINGLE;
		else if (config_error)
			err_pat = PAT_BLINK;
		else if (boot_err)
			err_pat = PAT_FLICKER;
		else
			err_pat = PAT_OFF;
	end

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.prog_err = drive_error;
		nxt_st.ready = drive_init_done && !drive_error;
		nxt_st.hold_a = dsl_hold_next(activity_a, tick, st_ff.hold_a);
		nxt_st.hold_b = dsl_hold_next(activity_b, tick, st_ff.hold_b);
		nxt_st.act_a = dsl_act_lamp(link_a, st_ff.hold_a, phase);
		nxt_st.act_b = dsl_act_lamp(link_b, st_ff.hold_b, phase);
		// Error lamp on the raw phase, run lamp shifted half a period
		nxt_st.err = dsl_pat_level(err_pat, phase);
		nxt_st.run = dsl_pat_level(run_pat, dsl_anti_phase(run_pat, phase));
		// Unfitted lamps held dark; cheaper than removing the ports per build
		if (CAN_BUILD)
		begin
			nxt_st.act_a = 1'b0;
			nxt_st.act_b = 1'b0;
			nxt_st.run = 1'b0;
			nxt_st.err = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st_ff.prog_err <= 1'b0;
			st_ff.ready <= 1'b0;
			st_ff.act_a <= 1'b0;
			st_ff.act_b <= 1'b0;
			st_ff.run <= 1'b0;
			st_ff.err <= 1'b0;
			st_ff.hold_a <= ACT_HOLD_RST;
			st_ff.hold_b <= ACT_HOLD_RST;
		end
		else
			st_ff <= nxt_st;
	end

	assign program_error_lamp = st_ff.prog_err;
	assign drive_ready_lamp = st_ff.ready;
	assign port_activity_lamp_a = st_ff.act_a;
	assign port_activity_lamp_b = st_ff.act_b;
	assign fieldbus_run_lamp = st_ff.run;
	assign fieldbus_error_lamp = st_ff.err;

	a_prog_err_on: assert property (@(posedge clk) disable iff (reset)
		drive_error |=> program_error_lamp)
		else $error("program error lamp not lit on drive error");

	a_ready_err_off: assert property (@(posedge clk) disable iff (reset)
		drive_error |=> !drive_ready_lamp && program_error_lamp)
		else $error("ready lamp lit during drive error");

	a_ready_on: assert property (@(posedge clk) disable iff (reset)
		drive_init_done && !drive_error |=> drive_ready_lamp)
		else $error("ready lamp dark after init");

	a_act_no_link: assert property (@(posedge clk) disable iff (reset)
		!link_a |=> !port_activity_lamp_a)
		else $error("activity lamp lit without link");

	a_act_traffic: assert property (@(posedge clk) disable iff (reset)
		!CAN_BUILD && activity_a && link_a ##1 link_a && phase[0] |=> !port_activity_lamp_a)
		else $error("traffic not shown on activity lamp");

	a_run_init_off: assert property (@(posedge clk) disable iff (reset)
		slave_state == SL_INIT |=> !fieldbus_run_lamp)
		else $error("run lamp lit in init");

	a_run_preop: assert property (@(posedge clk) disable iff (reset)
		!CAN_BUILD && slave_state == SL_PREOP && phase[2:0] == 3'h4 |=> fieldbus_run_lamp)
		else $error("run lamp blink not in antiphase");

	a_run_safeop: assert property (@(posedge clk) disable iff (reset)
		!CAN_BUILD && slave_state == SL_SAFEOP |=>
		fieldbus_run_lamp == ($past(phase) >= 5'h10 && $past(phase) < 5'h14))
		else $error("run lamp single flash wrong");

	a_run_op_on: assert property (@(posedge clk) disable iff (reset)
		!CAN_BUILD && slave_state == SL_OP |=> fieldbus_run_lamp)
		else $error("run lamp dark in operational");

	a_antiphase: assert property (@(posedge clk) disable iff (reset)
		slave_state == SL_SAFEOP && local_err && !ctrl_failure && !watchdog_timeout
		|=> !(fieldbus_run_lamp && fieldbus_error_lamp))
		else $error("run and error flashes overlap");

	a_err_ctrl_on: assert property (@(posedge clk) disable iff (reset)
		!CAN_BUILD && ctrl_failure |=> fieldbus_error_lamp)
		else $error("error lamp dark on controller failure");

	a_err_double: assert property (@(posedge clk) disable iff (reset)
		!CAN_BUILD && !ctrl_failure && watchdog_timeout |=>
		fieldbus_error_lamp == ($past(phase) < 5'h04 ||
		($past(phase) >= 5'h08 && $past(phase) < 5'h0c)))
		else $error("watchdog double flash wrong");

	a_err_local: assert property (@(posedge clk) disable iff (reset)
		!CAN_BUILD && !ctrl_failure && !watchdog_timeout && local_err |=>
		fieldbus_error_lamp == ($past(phase) < 5'h04))
		else $error("local error single flash wrong");

	a_err_config: assert property (@(posedge clk) disable iff (reset)
		!CAN_BUILD && !ctrl_failure && !watchdog_timeout && !local_err && config_error
		|=> fieldbus_error_lamp == !$past(phase[2]))
		else $error("configuration blink wrong or outranked");

	a_err_boot: assert property (@(posedge clk) disable iff (reset)
		!CAN_BUILD && boot_err && !ctrl_failure && !watchdog_timeout && !config_error
		|=> fieldbus_error_lamp == !$past(phase[0]))
		else $error("booting error flicker wrong");

	a_err_none_off: assert property (@(posedge clk) disable iff (reset)
		!ctrl_failure && !watchdog_timeout && !al_error_indicator && !config_error
		|=> !fieldbus_error_lamp)
		else $error("error lamp lit without error");

	a_can_dark: assert property (@(posedge clk) disable iff (reset)
		CAN_BUILD |-> !fieldbus_run_lamp && !fieldbus_error_lamp &&
		!port_activity_lamp_a && !port_activity_lamp_b)
		else $error("fieldbus lamp lit on CAN build");

endmodule : dsl_led_driver

/* File: hw/dsl_pkg.sv */
package dsl_pkg;

	// Slave state of the fieldbus state machine
	typedef enum logic [1:0]
	{
		SL_INIT,
		SL_PREOP,
		SL_SAFEOP,
		SL_OP
	} dsl_slave_t;

	// Lamp patterns
	typedef enum logic [2:0]
	{
		PAT_OFF,
		PAT_ON,
		PAT_BLINK,
		PAT_FLICKER,
		PAT_SINGLE,
		PAT_DOUBLE
	} dsl_pat_t;

	// Timebase
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_MS = 50;
	localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;

	// Pattern frame in ticks, phase counter width
	localparam int PHASE_W = 5;
	localparam logic [4:0] PHASE_RST = 5'h00;
	localparam logic [4:0] BLINK_HALF = 5'h04;
	localparam logic [4:0] FLASH_ON = 5'h04;
	localparam logic [4:0] DBL_GAP_END = 5'h08;
	localparam logic [4:0] DBL_ON2_END = 5'h0c;
	localparam logic [4:0] FRAME_HALF = 5'h10;

	// Activity stretch in ticks
	localparam logic [2:0] ACT_HOLD_TICKS = 3'h2;
	localparam logic [2:0] ACT_HOLD_RST = 3'h0;

	// Lamp level of a pattern at a given phase
	function automatic logic dsl_pat_level(dsl_pat_t pat, logic [4:0] ph);
		logic lvl;
		lvl = 1'b0;
		unique case (pat)
			PAT_OFF: lvl = 1'b0;
			PAT_ON: lvl = 1'b1;
			PAT_BLINK: lvl = (ph[2:0] < BLINK_HALF[2:0]);
			PAT_FLICKER: lvl = ~ph[0];
			PAT_SINGLE: lvl = (ph < FLASH_ON);
			PAT_DOUBLE: lvl = (ph < FLASH_ON) || (ph >= DBL_GAP_END && ph < DBL_ON2_END);
			default: lvl = 1'b0;
		endcase
		return lvl;
	endfunction : dsl_pat_level

	// Half-period shift that puts the run lamp in antiphase
	function automatic logic [4:0] dsl_anti_phase(dsl_pat_t pat, logic [4:0] ph);
		logic [4:0] r;
		r = ph;
		if (pat == PAT_BLINK)
			r = ph + BLINK_HALF;
		else if (pat == PAT_SINGLE || pat == PAT_DOUBLE)
			r = ph + FRAME_HALF;
		return r;
	endfunction : dsl_anti_phase

endpackage : dsl_pkg

/* File: hw/dsl_timebase.sv */
`timescale 1ns/1ps
module dsl_timebase #(
	parameter int TICK_CYCLES = dsl_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Timebase
	output logic tick,
	output logic [dsl_pkg::PHASE_W-1:0] phase
);
	import dsl_pkg::*;

	localparam int CW = $clog2(TICK_CYCLES);

	if (TICK_CYCLES < 2)
	begin : g_chk
		$error("TICK_CYCLES must be at least 2");
	end

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
		logic [PHASE_W-1:0] phase;
	} dsl_tb_state_t;

	dsl_tb_state_t st_ff;
	dsl_tb_state_t nxt_st;

	// Free running, never stopped, so all lamps share one phase
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (st_ff.cnt == CW'(TICK_CYCLES - 1))
		begin
			nxt_st.cnt = '0;
			nxt_st.tick = 1'b1;
			nxt_st.phase = st_ff.phase + 5'h01;
		end
		else
			nxt_st.cnt = st_ff.cnt + CW'(1);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st_ff.cnt <= '0;
			st_ff.tick <= 1'b0;
			st_ff.phase <= PHASE_RST;
		end
		else
			st_ff <= nxt_st;
	end

	assign tick = st_ff.tick;
	assign phase = st_ff.phase;

	a_tick_single: assert property (@(posedge clk) disable iff (reset)
		tick |=> !tick)
		else $error("tick lasted more than one cycle");

	a_phase_step: assert property (@(posedge clk) disable iff (reset)
		tick |-> phase == $past(phase) + 5'h01)
		else $error("phase did not advance with tick");

endmodule : dsl_timebase

/* File: verif/dsl_lamp_panel.sv */
`timescale 1ns/1ps
// Front panel model: counts lit cycles, turn-ons and run/error overlap
module dsl_lamp_panel (
	// Clock and control
	input wire logic clk,
	input wire logic clr,
	// Lamps: 0 run, 1 error, 2 activity a, 3 activity b
	input wire logic [3:0] lamp
);
	int on_cnt [4];
	int rise_cnt [4];
	int both_cnt;
	logic [3:0] last;
	always @(posedge clk)
	begin
		for (int i = 0; i < 4; i++)
		begin
			on_cnt[i] <= clr ? 0 : on_cnt[i] + int'(lamp[i] === 1'b1);
			rise_cnt[i] <= clr ? 0 : rise_cnt[i] + int'(lamp[i] === 1'b1 && last[i] !== 1'b1);
		end
		both_cnt <= clr ? 0 : both_cnt + int'(lamp[0] === 1'b1 && lamp[1] === 1'b1);
		last <= lamp;
	end
endmodule : dsl_lamp_panel

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
	import dsl_pkg::*;
	// Short tick keeps one 32-tick frame at 128 cycles
	localparam int TC = 4;
	localparam int FRAME = 32 * TC;
	localparam int LIMIT = 8000;
	int on_ticks [6] = '{0, 32, 16, 16, 4, 8};
	int rise_t [6] = '{0, 0, 4, 16, 1, 2};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic clr = 1'b0;
	logic drive_init_done = 1'b0;
	logic drive_error = 1'b0;
	logic link_a = 1'b0;
	logic activity_a = 1'b0;
	logic link_b = 1'b0;
	logic activity_b = 1'b0;
	dsl_slave_t slave_state = SL_INIT;
	logic al_error_indicator = 1'b0;
	logic ctrl_failure = 1'b0;
	logic watchdog_timeout = 1'b0;
	logic config_error = 1'b0;
	logic program_error_lamp;
	logic drive_ready_lamp;
	logic [3:0] lamps;
	logic [3:0] can_lamps;
	int bad_count = 0;
	int checks = 0;
	int cycles = 0;

	always #10 clk = ~clk;

	dsl_led_driver #(.TICK_CYCLES(TC), .CAN_BUILD(1'b0)) u_dsl_led_driver (.clk(clk),
		.reset(reset), .drive_init_done(drive_init_done), .drive_error(drive_error),
		.link_a(link_a), .activity_a(activity_a), .link_b(link_b), .activity_b(activity_b),
		.slave_state(slave_state), .al_error_indicator(al_error_indicator),
		.ctrl_failure(ctrl_failure), .watchdog_timeout(watchdog_timeout),
		.config_error(config_error), .program_error_lamp(program_error_lamp),
		.drive_ready_lamp(drive_ready_lamp), .port_activity_lamp_a(lamps[2]),
		.port_activity_lamp_b(lamps[3]), .fieldbus_run_lamp(lamps[0]),
		.fieldbus_error_lamp(lamps[1]));
	// Same stimulus into the CAN build
	dsl_led_driver #(.TICK_CYCLES(TC), .CAN_BUILD(1'b1)) u_dsl_led_driver_can (.clk(clk),
		.reset(reset), .drive_init_done(drive_init_done), .drive_error(drive_error),
		.link_a(link_a), .activity_a(activity_a), .link_b(link_b), .activity_b(activity_b),
		.slave_state(slave_state), .al_error_indicator(al_error_indicator),
		.ctrl_failure(ctrl_failure), .watchdog_timeout(watchdog_timeout),
		.config_error(config_error), .program_error_lamp(), .drive_ready_lamp(),
		.port_activity_lamp_a(can_lamps[2]), .port_activity_lamp_b(can_lamps[3]),
		.fieldbus_run_lamp(can_lamps[0]), .fieldbus_error_lamp(can_lamps[1]));
	dsl_lamp_panel u_dsl_lamp_panel (.clk(clk), .clr(clr), .lamp(lamps));
	// Never cleared after reset, so it totals the whole run
	dsl_lamp_panel u_dsl_lamp_panel_can (.clk(clk), .clr(reset), .lamp(can_lamps));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: seen %0d expected %0d", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	// Settle past the register stage, then count exactly one frame
	task automatic measure();
		repeat (3) @(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (FRAME) @(posedge clk);
		#1;
	endtask : measure

	task automatic frame_check(input int i, input dsl_pat_t p);
		check(u_dsl_lamp_panel.on_cnt[i], on_ticks[p] * TC);
		check(u_dsl_lamp_panel.rise_cnt[i], rise_t[p]);
	endtask : frame_check

	task automatic drive_lamps();
		logic [1:0] seq [3] = '{2'h2, 2'h3, 2'h2};
		check(drive_ready_lamp, 1'b0);
		foreach (seq[k])
		begin
			@(posedge clk);
			{drive_init_done, drive_error} <= seq[k];
			@(posedge clk);
			#1;
			check(program_error_lamp, seq[k][0]);
			check(drive_ready_lamp, !seq[k][0]);
		end
	endtask : drive_lamps

	task automatic run_states();
		dsl_pat_t run_pat [4] = '{PAT_OFF, PAT_BLINK, PAT_SINGLE, PAT_ON};
		for (int s = 0; s < 4; s++)
		begin
			@(posedge clk);
			slave_state <= dsl_slave_t'(s);
			measure();
			frame_check(0, run_pat[s]);
			frame_check(1, PAT_OFF);
		end
	endtask : run_states

	// Bits: failure, watchdog, error bit, config, slave state
	task automatic error_classes();
		logic [5:0] cond [6] = '{6'h33, 6'h19, 6'h0d, 6'h0c, 6'h08, 6'h03};
		dsl_pat_t ep [6] = '{PAT_ON, PAT_DOUBLE, PAT_SINGLE, PAT_BLINK, PAT_FLICKER, PAT_OFF};
		foreach (cond[k])
		begin
			@(posedge clk);
			{ctrl_failure, watchdog_timeout, al_error_indicator, config_error} <= cond[k][5:2];
			slave_state <= dsl_slave_t'(cond[k][1:0]);
			measure();
			frame_check(1, ep[k]);
		end
	endtask : error_classes

	// Same pattern on both lamps must never overlap when offset by half
	task automatic antiphase();
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk);
			slave_state <= k ? SL_SAFEOP : SL_PREOP;
			config_error <= ~k[0];
			al_error_indicator <= k[0];
			measure();
			frame_check(0, k ? PAT_SINGLE : PAT_BLINK);
			frame_check(1, k ? PAT_SINGLE : PAT_BLINK);
			check(u_dsl_lamp_panel.both_cnt, 0);
		end
	endtask : antiphase

	task automatic activity();
		@(posedge clk);
		link_a <= 1'b1;
		link_b <= 1'b1;
		activity_a <= 1'b1;
		measure();
		frame_check(2, PAT_FLICKER);
		frame_check(3, PAT_ON);
		@(posedge clk);
		link_a <= 1'b0;
		activity_b <= 1'b1;
		repeat (4 * TC) @(posedge clk);
		measure();
		frame_check(2, PAT_OFF);
		frame_check(3, PAT_FLICKER);
	endtask : activity

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			bad_count++;
			finish_test();
		end
	end

	initial
	begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		drive_lamps();
		run_states();
		error_classes();
		antiphase();
		activity();
		for (int i = 0; i < 4; i++)
			check(u_dsl_lamp_panel_can.on_cnt[i], 0);
		finish_test();
	end
endmodule : tb
